// file: verilog/acp_mode_config.sv
/*
 * Mode configuration port of a sampling converter. Either three pins act as
 * static straps, or they form a serial write/readback port into the mode
 * registers. Drives the resulting mode controls, the forwarded sample clock,
 * the digital output enable and a nap recovery flag.
 * Assumes all pins are asynchronous to ref_clk_i and the serial clock is
 * well below a quarter of the 25 MHz reference so its edges can be found.
 */
// Behaviour
// R01 - Output disable releases every digital output, forwarded clock included; code only drops digital_output_oe_o, forwarded clock keeps running.
// R02 - Host uses output disable only for long idle periods, not bus sharing.
// R03 - Sleep powers down the whole converter; from register or SDI pin.
// R04 - Host treats results as unsettled for 2ms after sleep.
// R05 - Nap keeps references on; data valid after 100 sample clocks.
// R06 - Host may wait a further 50us after nap recovery.
// R07 - Mode select pin high gives pin straps, low gives serial port.
// R08 - Strap mode: chip select level drives the duty cycle stabilizer.
// R09 - Strap mode: SCK level picks full-rate or double-data-rate outputs.
// R10 - Strap mode: SDI level high means sleep, low normal.
// R11 - Frame spans chip select low; only first 16 SCK rises sample SDI.
// R12 - Word is flag bit, seven address bits, eight data bits, MSB first.
// R13 - Flag zero writes the data bits to the addressed register.
// R14 - Flag one reads the register back on SDO, leaving it unchanged.
// R15 - SDO only pulls low or releases; host supplies the pull-up.
// R16 - Host's first serial command must be a software reset.
// R17 - Reset bit set clears all mode registers and clears itself.
// R18 - Power field selects normal, nap or sleep; nap only here.
// R19 - Timing bit 3 inverts the forwarded output clock.
// R20 - Timing bits 2-1 delay the forwarded clock by eighths.
// R21 - Host turns stabilizer on whenever a clock delay is selected.
// R22 - Timing bit 0 switches the duty cycle stabilizer.
// R23 - Output mode bit 2 disables the digital outputs.
// R24 - Readback bits change after SCK falls, MSB first.
// R25 - A frame shorter than 16 bits changes no register.
`timescale 1ns/100ps
module acp_mode_config
   import acp_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       programming_mode_select_i,
   input  wire logic       cs_n_i,
   input  wire logic       sck_i,
   input  wire logic       sdi_i,
   input  wire logic       sample_clk_i,
   output logic            sdo_o,
   output logic            sdo_oe_o,
   output logic [1:0]      power_state_o,
   output logic            duty_cycle_stabilizer_enable_o,
   output logic            ddr_output_mode_o,
   output logic            output_clock_invert_o,
   output logic [1:0]      output_clock_delay_o,
   output logic            forwarded_sample_clock_o,
   output logic            digital_output_oe_o,
   output logic            core_data_valid_o
);

   // Whole state of the top module
   typedef struct packed {
      acp_frame_t  frame;
      logic [4:0]  bit_cnt;
      logic [7:0]  data_shift;
      logic        read_flag;
      logic [6:0]  reg_addr;
      logic        sck_prev;
      logic        cs_n_prev;
      logic        smp_prev;
      logic        wr_pulse;
      logic        sdo_pull;
      logic [6:0]  wake_cnt;
      logic        data_valid;
      logic [1:0]  power;
      logic        stab_en;
      logic        ddr_mode;
      logic        clk_inv;
      logic [1:0]  clk_delay;
      logic        fwd_clk;
      logic        dout_oe;
   } acp_top_state_t;

   acp_top_state_t state_reg;
   acp_top_state_t state_next;

   acp_pins_t      pins_raw;
   acp_pins_t      pins_sync;
   acp_ctrl_t      reg_ctrl;
   logic [7:0]     reg_rd_data;

   // Gather the pins for the synchroniser
   assign pins_raw.mode_par = programming_mode_select_i;
   assign pins_raw.cs_n     = cs_n_i;
   assign pins_raw.sck      = sck_i;
   assign pins_raw.sdi      = sdi_i;
   assign pins_raw.smp_clk  = sample_clk_i;

   // Every pin passes two flops before any logic sees it
   acp_pin_sync acp_pin_sync_i (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .pins_i    (pins_raw),
      .pins_o    (pins_sync)
   );

   // Mode registers, written only at the end of a complete frame
   acp_reg_bank acp_reg_bank_i (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (state_reg.wr_pulse),
      .addr_i    (state_reg.reg_addr),
      .wdata_i   (state_reg.data_shift),
      .ctrl_o    (reg_ctrl),
      .rd_data_o (reg_rd_data)
   );

   // Serial frame engine, mode muxing and nap recovery
   always_comb begin
      logic sck_rise;
      logic sck_fall;
      logic cs_rise;
      logic smp_rise;
      logic serial_mode;
      logic [1:0] eff_power;

      sck_rise    = pins_sync.sck & ~state_reg.sck_prev;
      sck_fall    = ~pins_sync.sck & state_reg.sck_prev;
      cs_rise     = pins_sync.cs_n & ~state_reg.cs_n_prev;
      smp_rise    = pins_sync.smp_clk & ~state_reg.smp_prev;
      serial_mode = ~pins_sync.mode_par;  // R07
      eff_power   = PWR_NORMAL;

      state_next           = state_reg;
      state_next.sck_prev  = pins_sync.sck;
      state_next.cs_n_prev = pins_sync.cs_n;
      state_next.smp_prev  = pins_sync.smp_clk;
      state_next.wr_pulse  = 1'b0;

      // Frame handling; strap mode keeps the engine parked
      if (!serial_mode) begin
         state_next.frame    = FR_IDLE;
         state_next.bit_cnt  = 5'h00;
         state_next.sdo_pull = 1'b0;
      end else if (pins_sync.cs_n) begin
         // Commit only a whole write word; short frames vanish
         if (cs_rise && state_reg.frame == FR_DONE && !state_reg.read_flag) begin  // R25
            state_next.wr_pulse = 1'b1;  // R13
         end
         state_next.frame    = FR_IDLE;  // R11
         state_next.bit_cnt  = 5'h00;
         state_next.sdo_pull = 1'b0;
      end else begin
         unique case (state_reg.frame)
            FR_IDLE: begin
               // Chip select low opens a frame
               state_next.frame     = FR_SHIFT;  // R11
               state_next.bit_cnt   = 5'h00;
               state_next.read_flag = 1'b0;
            end
            FR_SHIFT: begin
               if (sck_rise) begin
                  // Header bits go to flag and address, the rest to data
                  if (state_reg.bit_cnt == 5'h00) begin
                     state_next.read_flag = pins_sync.sdi;  // R12
                  end else if (state_reg.bit_cnt <= HDR_LAST_IDX) begin
                     state_next.reg_addr = {state_reg.reg_addr[5:0], pins_sync.sdi};  // R12
                  end else begin
                     state_next.data_shift = {state_reg.data_shift[6:0], pins_sync.sdi};  // R12
                  end
                  state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
                  if (state_reg.bit_cnt == FRAME_BITS - 5'h01) begin
                     state_next.frame = FR_DONE;
                  end
               end
               // Readback bit moves after the falling edge, MSB first
               if (sck_fall && state_reg.read_flag && state_reg.bit_cnt >= DATA_FIRST_IDX) begin  // R24
                  state_next.sdo_pull = ~reg_rd_data[~state_reg.bit_cnt[2:0]];  // R14 R15
               end
            end
            FR_DONE: begin
               // Further rising edges are ignored; free the line after the last bit
               if (sck_fall) begin  // R11
                  state_next.sdo_pull = 1'b0;
               end
            end
            default: begin
               state_next.frame = FR_IDLE;
            end
         endcase
      end

      // Controls come from the straps or from the registers
      if (serial_mode) begin
         eff_power            = reg_ctrl.power_state;  // R03 R18
         state_next.stab_en   = reg_ctrl.stab_en;  // R22
         state_next.ddr_mode  = 1'b0;
         state_next.clk_inv   = reg_ctrl.clk_invert;  // R19
         state_next.clk_delay = reg_ctrl.clk_delay;  // R20
         state_next.dout_oe   = ~reg_ctrl.out_disable;  // R01 R23
      end else begin
         eff_power            = pins_sync.sdi ? PWR_SLEEP : PWR_NORMAL;  // R03 R10
         state_next.stab_en   = pins_sync.cs_n;  // R08
         state_next.ddr_mode  = pins_sync.sck;  // R09
         state_next.clk_inv   = 1'b0;
         state_next.clk_delay = 2'h0;
         state_next.dout_oe   = 1'b1;
      end
      state_next.power = eff_power;

      // Forwarded clock follows the sample clock, optionally inverted
      state_next.fwd_clk = pins_sync.smp_clk ^ state_next.clk_inv;  // R19

      // Count sample clocks after power-down ends before data is good
      if (eff_power != PWR_NORMAL) begin  // R05
         state_next.wake_cnt   = 7'h00;
         state_next.data_valid = 1'b0;
      end else if (smp_rise && state_reg.wake_cnt < NAP_WAKE_CYCLES) begin
         state_next.wake_cnt   = state_reg.wake_cnt + 7'h01;
         state_next.data_valid = (state_reg.wake_cnt + 7'h01) == NAP_WAKE_CYCLES;  // R05
      end
   end

   // Single register stage for all state
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg           <= '0;
         state_reg.frame     <= FR_IDLE;
         state_reg.cs_n_prev <= 1'b1;
         state_reg.dout_oe   <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flops; SDO only ever drives low
   assign sdo_o                          = 1'b0;  // R15
   assign sdo_oe_o                       = state_reg.sdo_pull;
   assign power_state_o                  = state_reg.power;
   assign duty_cycle_stabilizer_enable_o = state_reg.stab_en;
   assign ddr_output_mode_o              = state_reg.ddr_mode;
   assign output_clock_invert_o          = state_reg.clk_inv;
   assign output_clock_delay_o           = state_reg.clk_delay;
   assign forwarded_sample_clock_o       = state_reg.fwd_clk;
   assign digital_output_oe_o            = state_reg.dout_oe;
   assign core_data_valid_o              = state_reg.data_valid;

endmodule

// file: verilog/acp_pkg.sv
/*
 * Shared constants and types for the converter mode configuration port:
 * register addresses, field positions, reset values, power codes and the
 * packed carriers used between the top module and its two helpers.
 * Assumes a single 25 MHz reference clock with a synchronous reset.
 */
package acp_pkg;

   // Reference clock rate
   localparam int unsigned REF_CLK_HZ       = 25_000_000;

   // Serial word layout: one flag bit, seven address bits, eight data bits
   localparam int unsigned ADDR_W           = 7;
   localparam int unsigned DATA_W           = 8;
   localparam logic [4:0]  FRAME_BITS       = 5'h10;
   localparam logic [4:0]  HDR_LAST_IDX     = 5'h07;
   localparam logic [4:0]  DATA_FIRST_IDX   = 5'h08;

   // Register addresses
   localparam logic [6:0]  ADDR_SOFT_RESET  = 7'h00;
   localparam logic [6:0]  ADDR_POWER_STATE = 7'h01;
   localparam logic [6:0]  ADDR_CLK_TIMING  = 7'h02;
   localparam logic [6:0]  ADDR_OUTPUT_MODE = 7'h03;

   // Field positions
   localparam int unsigned SOFT_RESET_BIT   = 7;
   localparam int unsigned POWER_LSB        = 0;
   localparam int unsigned STAB_BIT         = 0;
   localparam int unsigned DELAY_LSB        = 1;
   localparam int unsigned INVERT_BIT       = 3;
   localparam int unsigned OUT_DISABLE_BIT  = 2;

   // Values after reset
   localparam logic [7:0]  REG_RESET_VAL    = 8'h00;

   // Power state field codes
   localparam logic [1:0]  PWR_NORMAL       = 2'h0;
   localparam logic [1:0]  PWR_NAP          = 2'h1;
   localparam logic [1:0]  PWR_SLEEP        = 2'h3;

   // Sample clock cycles the core needs after leaving nap
   localparam logic [6:0]  NAP_WAKE_CYCLES  = 7'h64;

   // Pins as sampled, packed as {mode_par, cs_n, sck, sdi, smp_clk}
   typedef struct packed {
      logic mode_par;
      logic cs_n;
      logic sck;
      logic sdi;
      logic smp_clk;
   } acp_pins_t;

   // Chip select idles high, everything else low
   localparam acp_pins_t PINS_RESET_VAL     = 5'h08;

   // Mode controls that leave the register bank
   typedef struct packed {
      logic [1:0] power_state;
      logic       clk_invert;
      logic [1:0] clk_delay;
      logic       stab_en;
      logic       out_disable;
   } acp_ctrl_t;

   // Serial frame progress
   typedef enum logic [1:0] {
      FR_IDLE,
      FR_SHIFT,
      FR_DONE
   } acp_frame_t;

endpackage

// file: verilog/acp_pin_sync.sv
/*
 * Two-stage synchroniser for every pin that reaches the configuration port.
 * Assumes the pins are asynchronous to ref_clk_i; only stage two is read.
 */
`timescale 1ns/100ps
module acp_pin_sync
   import acp_pkg::*;
(
   input  wire logic      ref_clk_i,
   input  wire logic      rst_i,
   input  wire acp_pins_t pins_i,
   output acp_pins_t      pins_o
);

   typedef struct packed {
      acp_pins_t stage1;
      acp_pins_t stage2;
   } acp_sync_state_t;

   acp_sync_state_t sync_reg;
   acp_sync_state_t sync_next;

   // Stage one feeds stage two only
   always_comb begin
      sync_next        = sync_reg;
      sync_next.stage1 = pins_i;
      sync_next.stage2 = sync_reg.stage1;
   end

   // Reset to idle pin levels so no false frame starts
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync_reg <= {PINS_RESET_VAL, PINS_RESET_VAL};
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign pins_o = sync_reg.stage2;

endmodule

// file: verilog/acp_reg_bank.sv
/*
 * Mode control registers: power state, output clock timing and the output
 * disable bit, plus the self-clearing software reset. Assumes writes arrive
 * as one-cycle pulses from the serial frame engine on the same clock.
 */
`timescale 1ns/100ps
module acp_reg_bank
   import acp_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        wr_en_i,
   input  wire logic [6:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   output acp_ctrl_t        ctrl_o,
   output logic      [7:0]  rd_data_o
);

   typedef struct packed {
      logic [1:0] power;
      logic [3:0] timing;
      logic       out_dis;
      logic [7:0] rd_data;
   } acp_bank_state_t;

   acp_bank_state_t bank_reg;
   acp_bank_state_t bank_next;

   // Write decode, soft reset and registered readback
   always_comb begin
      bank_next = bank_reg;
      if (wr_en_i) begin
         unique case (addr_i)
            ADDR_SOFT_RESET: begin
               if (wdata_i[SOFT_RESET_BIT]) begin  // R17
                  bank_next.power   = REG_RESET_VAL[1:0];
                  bank_next.timing  = REG_RESET_VAL[3:0];
                  bank_next.out_dis = REG_RESET_VAL[0];
               end
            end
            ADDR_POWER_STATE: bank_next.power   = wdata_i[POWER_LSB +: 2];  // R18
            ADDR_CLK_TIMING:  bank_next.timing  = wdata_i[3:0];  // R22
            ADDR_OUTPUT_MODE: bank_next.out_dis = wdata_i[OUT_DISABLE_BIT];  // R23
            default:          bank_next.power   = bank_reg.power;
         endcase
      end
      // Reset bit is never stored, so it always reads back as zero
      unique case (addr_i)
         ADDR_POWER_STATE: bank_next.rd_data = {6'h00, bank_reg.power};
         ADDR_CLK_TIMING:  bank_next.rd_data = {4'h0, bank_reg.timing};
         ADDR_OUTPUT_MODE: bank_next.rd_data = {5'h00, bank_reg.out_dis, 2'h0};
         default:          bank_next.rd_data = REG_RESET_VAL;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         bank_reg <= '0;
      end else begin
         bank_reg <= bank_next;
      end
   end

   // Field outputs straight from the flops
   assign ctrl_o.power_state = bank_reg.power;
   assign ctrl_o.clk_invert  = bank_reg.timing[INVERT_BIT];  // R19
   assign ctrl_o.clk_delay   = bank_reg.timing[DELAY_LSB +: 2];  // R20
   assign ctrl_o.stab_en     = bank_reg.timing[STAB_BIT];  // R22
   assign ctrl_o.out_disable = bank_reg.out_dis;
   assign rd_data_o          = bank_reg.rd_data;

endmodule

// file: dv/acp_host_model.sv
/*
 * Host model for the serial configuration port: framed SCK at 320 ns.
 * Assumes the bench resolves the open-drain SDO wire with a pull-up.
 */
`timescale 1ns/100ps
module acp_host_model (
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      sdi_o,
   input  wire logic sdo_line_i
);
   // Idle: deselected, SCK still
   initial begin
      cs_n_o = 1'b1;
      sck_o  = 1'b0;
      sdi_o  = 1'b0;
   end

   // One frame of n SCK pulses; offset keeps edges off the ref clock
   task automatic frame(input logic [15:0] word, input int n, output logic [7:0] rd);
      rd = 8'h00;
      #7;
      cs_n_o = 1'b0;
      #160;
      for (int i = 0; i < n; i++) begin
         sdi_o = (i < 16) ? word[15 - i] : ~sdi_o;
         #160;
         if (i >= 8 && i < 16) rd[15 - i] = sdo_line_i;
         sck_o = 1'b1;
         #160;
         sck_o = 1'b0;
      end
      #160;
      cs_n_o = 1'b1;
      sdi_o  = ~sdi_o; // Stale data never lingers on a released line
      #480;
   endtask
endmodule

// file: dv/acp_mode_config_sva.sv
/*
 * Port checker for the mode configuration port.
 * Assumes pins change off the ref clock edge; bound from the bench top.
 */
`timescale 1ns/100ps
module acp_mode_config_sva
   import acp_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic       programming_mode_select_i,
   input wire logic       cs_n_i,
   input wire logic       sck_i,
   input wire logic       sdi_i,
   input wire logic       sample_clk_i,
   input wire logic       sdo_o,
   input wire logic       sdo_oe_o,
   input wire logic [1:0] power_state_o,
   input wire logic       duty_cycle_stabilizer_enable_o,
   input wire logic       ddr_output_mode_o,
   input wire logic       output_clock_invert_o,
   input wire logic [1:0] output_clock_delay_o,
   input wire logic       forwarded_sample_clock_o,
   input wire logic       digital_output_oe_o,
   input wire logic       core_data_valid_o
);
   logic       smp_reg;
   logic [7:0] rise_reg;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // Sample clock rises since power last returned to normal; saturates
   always_ff @(posedge ref_clk_i) begin
      smp_reg <= sample_clk_i;
      if (rst_i || power_state_o != 2'h0) rise_reg <= 8'h00;
      else if (sample_clk_i && !smp_reg && rise_reg != 8'hff) rise_reg <= rise_reg + 8'h01;
   end

   property p_sdo_low;
      sdo_oe_o |-> !sdo_o;
   endproperty
   a_sdo_low: assert property (p_sdo_low) else $error("sdo driven high");
   property p_sdo_idle;
      (cs_n_i || programming_mode_select_i)[*5] |-> !sdo_oe_o;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle) else $error("sdo pulled outside frame");
   property p_strap_stab;
      (programming_mode_select_i && $stable(cs_n_i))[*5] |-> duty_cycle_stabilizer_enable_o == cs_n_i;
   endproperty
   a_strap_stab: assert property (p_strap_stab) else $error("strap stabilizer wrong");
   property p_strap_ddr;
      (programming_mode_select_i && $stable(sck_i))[*5] |-> ddr_output_mode_o == sck_i;
   endproperty
   a_strap_ddr: assert property (p_strap_ddr) else $error("strap output mode wrong");
   property p_strap_power;
      (programming_mode_select_i && $stable(sdi_i))[*5] |-> power_state_o == {sdi_i, sdi_i};
   endproperty
   a_strap_power: assert property (p_strap_power) else $error("strap power wrong");
   property p_serial_ddr;
      (!programming_mode_select_i)[*5] |-> !ddr_output_mode_o;
   endproperty
   a_serial_ddr: assert property (p_serial_ddr) else $error("ddr set in serial mode");
   property p_quiet_regs;
      (!programming_mode_select_i && cs_n_i)[*8] ##1 (!programming_mode_select_i && cs_n_i)[*2]
         |-> $stable({power_state_o, output_clock_invert_o, output_clock_delay_o,
                      duty_cycle_stabilizer_enable_o, digital_output_oe_o});
   endproperty
   a_quiet_regs: assert property (p_quiet_regs) else $error("control moved without frame");
   property p_nap_drop;
      (power_state_o != 2'h0)[*2] |-> !core_data_valid_o;
   endproperty
   a_nap_drop: assert property (p_nap_drop) else $error("valid while powered down");
   property p_nap_wake;
      core_data_valid_o |-> rise_reg >= 8'h63;
   endproperty
   a_nap_wake: assert property (p_nap_wake) else $error("valid before wake count");
   property p_fwd_clk;
      ($stable(sample_clk_i) && $stable(output_clock_invert_o))[*4]
         |-> forwarded_sample_clock_o == (sample_clk_i ^ output_clock_invert_o);
   endproperty
   a_fwd_clk: assert property (p_fwd_clk) else $error("forwarded clock polarity wrong");

   c_read: cover property ($rose(sdo_oe_o));
   c_wake: cover property ($rose(core_data_valid_o));
   c_off: cover property ($fell(digital_output_oe_o));
endmodule

// file: dv/acp_mode_config_tb_top.sv
/*
 * Bench for the mode configuration port: table of serial writes and
 * straps, then short/long frames and nap recovery by hand.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/100ps
module acp_mode_config_tb_top import acp_pkg::*;;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic mode_sel = 1'b0;
   logic strap_cs = 1'b1, strap_sck = 1'b0, strap_sdi = 1'b0;
   logic smp_clk = 1'b0;
   logic [3:0] smp_div = 4'h0;
   logic h_cs, h_sck, h_sdi, sdo_line, sdo, sdo_oe, stab, ddr, inv, fwd, dout_oe, valid;
   logic [1:0] pwr, dly;
   logic [7:0] rd;
   int fails = 0, compares = 0, cycles = 0;
   // Rows: {strap, addr, data or pins, controls {pwr,inv,dly,stab,oe}, readback or ddr}
   logic [39:0] rows [14] = '{40'h0002_f103_01, 40'h0002_0b17_0b, 40'h0002_050b_05,
      40'h0002_070f_07, 40'h0001_fd2f_01, 40'h0001_036f_03, 40'h0001_024f_02,
      40'h0003_ff4e_04, 40'h0010_5a4e_00, 40'h0000_8001_00, 40'h0100_0001_00,
      40'h0100_0763_01, 40'h0100_0403_00, 40'h0100_0361_01};

   always #20 ref_clk_i = ~ref_clk_i;
   // Sample clock of ten ref cycles, so 100 rises take 1000 cycles
   always @(posedge ref_clk_i) begin
      smp_div <= (smp_div == 4'h4) ? 4'h0 : smp_div + 4'h1;
      if (smp_div == 4'h4) smp_clk <= ~smp_clk;
   end
   // Hang guard
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         fails = fails + 1;
         end_sim();
      end
   end
   assign sdo_line = sdo_oe ? sdo : 1'b1;

   acp_mode_config acp_mode_config_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .programming_mode_select_i(mode_sel), .cs_n_i(mode_sel ? strap_cs : h_cs),
      .sck_i(mode_sel ? strap_sck : h_sck), .sdi_i(mode_sel ? strap_sdi : h_sdi),
      .sample_clk_i(smp_clk), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .power_state_o(pwr),
      .duty_cycle_stabilizer_enable_o(stab), .ddr_output_mode_o(ddr), .output_clock_invert_o(inv),
      .output_clock_delay_o(dly), .forwarded_sample_clock_o(fwd), .digital_output_oe_o(dout_oe),
      .core_data_valid_o(valid));
   acp_host_model acp_host_model_i (.cs_n_o(h_cs), .sck_o(h_sck), .sdi_o(h_sdi), .sdo_line_i(sdo_line));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         fails++;
      end
   endtask
   task automatic ctl(input logic [7:0] exp);
      chk({1'b0, pwr, inv, dly, stab, dout_oe}, exp);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      acp_host_model_i.frame({1'b0, a, d}, 16, rd);
   endtask
   // Data bits on a read are junk on purpose; the port must ignore them
   task automatic rdb(input logic [6:0] a, input logic [7:0] exp);
      acp_host_model_i.frame({1'b1, a, 8'ha5}, 16, rd);
      chk(rd, exp);
   endtask
   task automatic end_sim();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
      ctl(8'h01);
      chk({4'h0, sdo_oe, valid, ddr, fwd}, 8'h00);
      repeat (3) @(posedge ref_clk_i);
      wr(ADDR_SOFT_RESET, 8'h80);
      rdb(ADDR_SOFT_RESET, 8'h00);
      foreach (rows[k]) begin
         @(posedge ref_clk_i);
         if (rows[k][39:32] != 8'h00) begin
            mode_sel <= 1'b1;
            {strap_cs, strap_sck, strap_sdi} <= rows[k][18:16];
            repeat (8) @(posedge ref_clk_i);
            #1;
            chk({7'h00, ddr}, rows[k][7:0]);
         end else begin
            wr(rows[k][30:24], rows[k][23:16]);
            rdb(rows[k][30:24], rows[k][7:0]);
         end
         ctl(rows[k][15:8]);
      end
      // Back to serial; straps left the registers alone
      @(posedge ref_clk_i);
      mode_sel <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      ctl(8'h01);
      acp_host_model_i.frame({1'b0, ADDR_CLK_TIMING, 8'h0f}, 10, rd);
      ctl(8'h01);
      acp_host_model_i.frame({1'b0, ADDR_CLK_TIMING, 8'h09}, 20, rd);
      ctl(8'h13);
      // Mid-run reset must clear the mode registers like a fresh start
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      ctl(8'h01);
      wr(ADDR_SOFT_RESET, 8'h80);
      // Nap, then wake: valid only after 100 sample clocks
      wr(ADDR_POWER_STATE, {6'h00, PWR_NAP});
      chk({7'h00, valid}, 8'h00);
      wr(ADDR_POWER_STATE, {6'h00, PWR_NORMAL});
      repeat (850) @(posedge ref_clk_i);
      chk({7'h00, valid}, 8'h00);
      repeat (300) @(posedge ref_clk_i);
      chk({7'h00, valid}, 8'h01);
      end_sim();
   end
endmodule

bind acp_mode_config acp_mode_config_sva acp_mode_config_sva_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .programming_mode_select_i(programming_mode_select_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
   .sdi_i(sdi_i), .sample_clk_i(sample_clk_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
   .power_state_o(power_state_o), .duty_cycle_stabilizer_enable_o(duty_cycle_stabilizer_enable_o),
   .ddr_output_mode_o(ddr_output_mode_o), .output_clock_invert_o(output_clock_invert_o),
   .output_clock_delay_o(output_clock_delay_o), .forwarded_sample_clock_o(forwarded_sample_clock_o),
   .digital_output_oe_o(digital_output_oe_o), .core_data_valid_o(core_data_valid_o));
